// ===== frf_pkg.sv
// Constants, register map and types of the frequency reference adjust block
package frf_pkg;

    // ==========================================
    // Clock and timing
    // ==========================================
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned SH_TIME_MS = 100;
    localparam int unsigned SH_CYCLES = SH_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned STEP_TIME_US = 1000;
    localparam int unsigned STEP_CYCLES = STEP_TIME_US * CLK_MHZ;

    // ==========================================
    // Terminals and function codes
    // ==========================================
    localparam int unsigned NUM_TERM = 10;
    localparam logic [7:0] FN_RAMP_HOLD = 8'h0A;
    localparam logic [7:0] FN_RAISE = 8'h10;
    localparam logic [7:0] FN_LOWER = 8'h11;
    localparam logic [7:0] FN_TRIM_INC = 8'h1C;
    localparam logic [7:0] FN_TRIM_DEC = 8'h1D;
    localparam logic [7:0] FN_SAMPLE_HOLD = 8'h1E;
    localparam logic [7:0] FN_RST = 8'h00;

    // ==========================================
    // Values in 0.1 % of maximum output frequency; trim values in 1 % steps, scaled by TRIM_SCALE
    // ==========================================
    typedef logic [11:0] frf_freq_type;
    localparam frf_freq_type PCT_MAX = 12'h044C;
    localparam frf_freq_type UPPER_RST = 12'h03E8;
    localparam frf_freq_type LOWER_RST = 12'h0000;
    localparam frf_freq_type MLOWER_RST = 12'h0000;
    localparam logic [6:0] TRIM_MAX = 7'h64;
    localparam logic [6:0] TRIM_RST = 7'h0A;
    localparam logic [3:0] TRIM_SCALE = 4'hA;

    // ==========================================
    // Register byte offsets
    // ==========================================
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_UPPER = 8'h04;
    localparam logic [7:0] OFS_LOWER = 8'h08;
    localparam logic [7:0] OFS_MLOWER = 8'h0C;
    localparam logic [7:0] OFS_TRIM = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_OUT_FREQ = 8'h18;
    localparam logic [7:0] OFS_UD_REF = 8'h1C;
    localparam logic [7:0] OFS_TERM0 = 8'h20;
    localparam logic [7:0] OFS_TERM_LAST = 8'h44;

    // Control bit positions and reset values
    localparam int unsigned CTRL_ANALOG_BIT = 0;
    localparam int unsigned CTRL_HOLD_BIT = 1;
    localparam logic CTRL_ANALOG_RST = 1'b1;
    localparam logic CTRL_HOLD_RST = 1'b0;

    // Status bit positions
    localparam int unsigned ST_AGREE_BIT = 0;
    localparam int unsigned ST_ERR_BIT = 1;
    localparam int unsigned ST_SH_BIT = 2;
    localparam int unsigned ST_RUN_BIT = 3;

    typedef enum logic [1:0] {SH_IDLE, SH_WAIT, SH_HELD} frf_sh_type;

endpackage : frf_pkg

// ===== frf_term_match.sv
// Match of one terminal function code against all terminal selectors
module frf_term_match #(
    parameter logic [7:0] CODE = 8'h00
) (
    input wire logic [frf_pkg::NUM_TERM*8-1:0] sel,
    input wire logic [frf_pkg::NUM_TERM-1:0] term_in,
    output logic assigned,
    output logic active
);
    import frf_pkg::*;

    // Any terminal holding the code assigns it; its contact activates it
    always_comb begin
        assigned = 1'b0;
        active = 1'b0;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (sel[i*8 +: 8] == CODE) begin
                assigned = 1'b1;
                active = active | term_in[i];
            end
        end
    end

endmodule : frf_term_match

// ===== frf_adjust.sv
// Frequency reference adjust: raise/lower, trim and sample/hold
module frf_adjust #(
    parameter int unsigned STEP_P = frf_pkg::STEP_CYCLES,
    parameter int unsigned SH_P = frf_pkg::SH_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [frf_pkg::NUM_TERM-1:0] term_in,
    input wire frf_pkg::frf_freq_type analog_ref,
    input wire logic run_cmd,
    input wire logic preset_active,
    input wire frf_pkg::frf_freq_type preset_ref,
    input wire frf_pkg::frf_freq_type nv_ref_in,
    output frf_pkg::frf_freq_type nv_ref_out,
    output frf_pkg::frf_freq_type out_freq,
    output logic freq_agree,
    output logic config_error
);
    import frf_pkg::*;

    // ==========================================
    // State
    // ==========================================
    typedef struct packed {
        logic [31:0] rdata;
        logic analog_src;
        logic hold_mem;
        frf_freq_type upper;
        frf_freq_type lower;
        frf_freq_type mlower;
        logic [6:0] trim;
        logic [NUM_TERM*8-1:0] sel;
        frf_freq_type ud_ref;
        frf_freq_type out_freq;
        frf_freq_type nv_out;
        logic agree;
        logic err;
        logic run_q;
        logic booted;
        logic restored;
        frf_sh_type sh_state;
        logic [31:0] sh_cnt;
        frf_freq_type sh_val;
        logic sh_valid;
        logic [31:0] tick_cnt;
    } frf_state_type;

    frf_state_type s;
    frf_state_type next_s;

    // ==========================================
    // Terminal function decode
    // ==========================================
    logic up_asg, up_on, dn_asg, dn_on;
    logic inc_asg, inc_on, dec_asg, dec_on;
    logic sh_asg, sh_on, rh_asg, rh_on;

    frf_term_match #(.CODE(FN_RAISE)) u_up (
        .sel(s.sel), .term_in(term_in), .assigned(up_asg), .active(up_on));
    frf_term_match #(.CODE(FN_LOWER)) u_dn (
        .sel(s.sel), .term_in(term_in), .assigned(dn_asg), .active(dn_on));
    frf_term_match #(.CODE(FN_TRIM_INC)) u_inc (
        .sel(s.sel), .term_in(term_in), .assigned(inc_asg), .active(inc_on));
    frf_term_match #(.CODE(FN_TRIM_DEC)) u_dec (
        .sel(s.sel), .term_in(term_in), .assigned(dec_asg), .active(dec_on));
    frf_term_match #(.CODE(FN_SAMPLE_HOLD)) u_sh (
        .sel(s.sel), .term_in(term_in), .assigned(sh_asg), .active(sh_on));
    frf_term_match #(.CODE(FN_RAMP_HOLD)) u_rh (
        .sel(s.sel), .term_in(term_in), .assigned(rh_asg), .active(rh_on));

    // ==========================================
    // Combinational helpers
    // ==========================================
    logic err_c;
    logic ud_mode;
    logic trim_mode;
    logic sh_mode;
    logic tick;
    logic run_rise;
    logic run_fall;
    frf_freq_type eff_low;
    frf_freq_type ud_clamp;
    frf_freq_type trimmed;
    frf_freq_type base;
    frf_freq_type target;
    logic signed [13:0] trim_sum;
    logic [10:0] trim_amt;

    // Assignment checks; any illegal mix disables all adjust functions
    always_comb begin
        err_c = (up_asg ^ dn_asg)
            | ((up_asg | dn_asg) & rh_asg)
            | (inc_asg ^ dec_asg)
            | (sh_asg & (rh_asg | up_asg | dn_asg | inc_asg | dec_asg));
        ud_mode = up_asg & dn_asg & ~err_c;
        trim_mode = inc_asg & dec_asg & ~err_c;
        sh_mode = sh_asg & ~err_c;
        tick = (s.tick_cnt == STEP_P - 1);
        run_rise = run_cmd & ~s.run_q;
        run_fall = ~run_cmd & s.run_q;
    end

    // Lower bound and clamp of the raise/lower reference
    always_comb begin
        eff_low = (s.lower > s.mlower) ? s.lower : s.mlower;
        if (s.analog_src && analog_ref > eff_low) begin
            eff_low = analog_ref;
        end
        // A lower bound above the upper limit yields to the upper limit
        if (eff_low > s.upper) begin
            eff_low = s.upper;
        end
        ud_clamp = s.ud_ref;
        if (ud_clamp > s.upper) begin
            ud_clamp = s.upper;
        end
        if (ud_clamp < eff_low) begin
            ud_clamp = eff_low;
        end
    end

    // Trim of the analog reference
    always_comb begin
        trim_amt = 11'(s.trim) * 11'(TRIM_SCALE);
        trim_sum = $signed({2'b00, analog_ref});
        if (inc_on && !dec_on) begin
            trim_sum = trim_sum + $signed({3'b000, trim_amt});
        end else if (dec_on && !inc_on) begin
            trim_sum = trim_sum - $signed({3'b000, trim_amt});
        end
        if (trim_sum <= 0) begin
            trimmed = '0;
        end else if (trim_sum > 14'sh0FFF) begin
            trimmed = 12'hFFF; // Saturate; a wrap would drop the speed
        end else begin
            trimmed = frf_freq_type'(trim_sum);
        end
    end

    // Reference selection; raise/lower outranks the preset speeds
    always_comb begin
        if (ud_mode) begin
            base = ud_clamp;
        end else if (sh_mode && s.sh_valid) begin
            base = s.sh_val;
        end else if (preset_active || !s.analog_src) begin
            base = preset_ref;
        end else if (trim_mode && analog_ref != '0) begin
            base = trimmed;
        end else begin
            base = analog_ref;
        end
        target = run_cmd ? base : '0;
    end

    // ==========================================
    // Next state
    // ==========================================
    always_comb begin
        next_s = s;
        next_s.err = err_c;
        next_s.run_q = run_cmd;
        next_s.tick_cnt = tick ? '0 : s.tick_cnt + 32'h0000_0001;

        // Power-up restore of the kept reference from outside storage
        if (!s.booted) begin
            next_s.booted = 1'b1;
            next_s.ud_ref = nv_ref_in;
            next_s.restored = (nv_ref_in != '0);
        end else if ((run_rise || run_fall) && !s.hold_mem) begin
            next_s.ud_ref = '0;
            next_s.restored = 1'b0;
        end else if (ud_mode && run_cmd && s.restored && (up_on || dn_on)) begin
            next_s.ud_ref = '0;
            next_s.restored = 1'b0;
        end else if (ud_mode && run_cmd && tick) begin
            // Steps start from the clamped value so limits bite at once
            next_s.ud_ref = ud_clamp;
            if (up_on && !dn_on && ud_clamp < s.upper) begin
                next_s.ud_ref = ud_clamp + 12'h001;
            end else if (dn_on && !up_on && ud_clamp > eff_low) begin
                next_s.ud_ref = ud_clamp - 12'h001;
            end
        end
        next_s.nv_out = s.hold_mem ? next_s.ud_ref : '0;

        // Output ramps one step per tick towards the target
        if (tick) begin
            if (s.out_freq < target) begin
                next_s.out_freq = s.out_freq + 12'h001;
            end else if (s.out_freq > target) begin
                next_s.out_freq = s.out_freq - 12'h001;
            end
        end
        next_s.agree = run_cmd && (next_s.out_freq == target);

        // Sample/hold: value taken only if contact lasts the full time
        unique case (s.sh_state)
            SH_IDLE: begin
                next_s.sh_cnt = '0;
                if (sh_mode && sh_on) begin
                    next_s.sh_state = SH_WAIT;
                end
            end
            SH_WAIT: begin
                if (!(sh_mode && sh_on)) begin
                    next_s.sh_state = SH_IDLE;
                end else if (s.sh_cnt == SH_P - 1) begin
                    next_s.sh_val = analog_ref;
                    next_s.sh_valid = 1'b1;
                    next_s.sh_state = SH_HELD;
                end else begin
                    next_s.sh_cnt = s.sh_cnt + 32'h0000_0001;
                end
            end
            SH_HELD: begin
                if (!sh_on) begin
                    next_s.sh_state = SH_IDLE;
                end
            end
            default: begin
                next_s.sh_state = SH_IDLE;
            end
        endcase

        // Register writes; limits, trim and the hold bit are frozen while running, source and selectors are not
        if (wr) begin
            if (addr == OFS_CTRL) begin
                next_s.analog_src = wdata[CTRL_ANALOG_BIT];
                if (!run_cmd) begin
                    next_s.hold_mem = wdata[CTRL_HOLD_BIT];
                end
            end else if (addr == OFS_UPPER) begin
                if (!run_cmd && wdata[31:0] <= 32'(PCT_MAX)) begin
                    next_s.upper = wdata[11:0];
                end
            end else if (addr == OFS_LOWER) begin
                if (!run_cmd && wdata[31:0] <= 32'(PCT_MAX)) begin
                    next_s.lower = wdata[11:0];
                end
            end else if (addr == OFS_MLOWER) begin
                if (!run_cmd && wdata[31:0] <= 32'(PCT_MAX)) begin
                    next_s.mlower = wdata[11:0];
                end
            end else if (addr == OFS_TRIM) begin
                if (!run_cmd && wdata[31:0] <= 32'(TRIM_MAX)) begin
                    next_s.trim = wdata[6:0];
                end
            end else if (addr >= OFS_TERM0 && addr <= OFS_TERM_LAST
                         && addr[1:0] == 2'b00) begin
                next_s.sel[(addr[7:2] - OFS_TERM0[7:2]) * 8 +: 8] = wdata[7:0];
            end
        end

        // Read data stand for one cycle only; unmapped reads give zero
        next_s.rdata = '0;
        if (rd) begin
            if (addr == OFS_CTRL) begin
                next_s.rdata[CTRL_ANALOG_BIT] = s.analog_src;
                next_s.rdata[CTRL_HOLD_BIT] = s.hold_mem;
            end else if (addr == OFS_UPPER) begin
                next_s.rdata[11:0] = s.upper;
            end else if (addr == OFS_LOWER) begin
                next_s.rdata[11:0] = s.lower;
            end else if (addr == OFS_MLOWER) begin
                next_s.rdata[11:0] = s.mlower;
            end else if (addr == OFS_TRIM) begin
                next_s.rdata[6:0] = s.trim;
            end else if (addr == OFS_STATUS) begin
                next_s.rdata[ST_AGREE_BIT] = s.agree;
                next_s.rdata[ST_ERR_BIT] = s.err;
                next_s.rdata[ST_SH_BIT] = s.sh_valid;
                next_s.rdata[ST_RUN_BIT] = s.run_q;
            end else if (addr == OFS_OUT_FREQ) begin
                next_s.rdata[11:0] = s.out_freq;
            end else if (addr == OFS_UD_REF) begin
                next_s.rdata[11:0] = s.ud_ref;
            end else if (addr >= OFS_TERM0 && addr <= OFS_TERM_LAST
                         && addr[1:0] == 2'b00) begin
                next_s.rdata[7:0] = s.sel[(addr[7:2] - OFS_TERM0[7:2]) * 8 +: 8];
            end
        end
    end

    // ==========================================
    // Registers; reset drops the held sample
    // ==========================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.analog_src <= CTRL_ANALOG_RST;
            s.hold_mem <= CTRL_HOLD_RST;
            s.upper <= UPPER_RST;
            s.lower <= LOWER_RST;
            s.mlower <= MLOWER_RST;
            s.trim <= TRIM_RST;
            s.sel <= {NUM_TERM{FN_RST}};
            s.sh_state <= SH_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state flops
    assign rdata = s.rdata;
    assign nv_ref_out = s.nv_out;
    assign out_freq = s.out_freq;
    assign freq_agree = s.agree;
    assign config_error = s.err;

endmodule : frf_adjust

// ===== frf_adjust_sva.sv
// Port checker of the frequency reference adjust block
module frf_adjust_sva #(
    parameter int unsigned STEP_P = 4,
    parameter int unsigned SH_P = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic run_cmd,
    input wire frf_pkg::frf_freq_type nv_ref_out,
    input wire frf_pkg::frf_freq_type out_freq,
    input wire logic freq_agree,
    input wire logic config_error
);
    import frf_pkg::*;
    // ========
    // Shadow of accepted settings
    // ========
    logic [31:0] upper_sh;
    logic [31:0] trim_sh;
    logic hold_sh;
    logic [7:0] sel_sh [NUM_TERM];
    logic [5:0] has;
    logic ud_bad;
    logic trim_bad;
    logic sh_bad;
    // Limit, trim and hold writes while running bounce, so the shadow skips them too
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_sh <= 32'(UPPER_RST);
            trim_sh <= 32'(TRIM_RST);
            hold_sh <= CTRL_HOLD_RST;
            for (int i = 0; i < NUM_TERM; i++) sel_sh[i] <= FN_RST;
        end else if (wr) begin
            if (addr == OFS_UPPER && !run_cmd && wdata <= 32'(PCT_MAX)) upper_sh <= wdata;
            if (addr == OFS_TRIM && !run_cmd && wdata <= 32'(TRIM_MAX)) trim_sh <= wdata;
            if (addr == OFS_CTRL && !run_cmd) hold_sh <= wdata[CTRL_HOLD_BIT];
            for (int i = 0; i < NUM_TERM; i++) if (addr == OFS_TERM0 + 8'(4 * i)) sel_sh[i] <= wdata[7:0];
        end
    end
    // Which adjust functions some terminal carries
    always_comb begin
        has = '0;
        for (int i = 0; i < NUM_TERM; i++) begin
            has |= {sel_sh[i] == FN_SAMPLE_HOLD, sel_sh[i] == FN_TRIM_DEC, sel_sh[i] == FN_TRIM_INC,
                    sel_sh[i] == FN_RAMP_HOLD, sel_sh[i] == FN_LOWER, sel_sh[i] == FN_RAISE};
        end
        ud_bad = (has[0] ^ has[1]) | ((has[0] | has[1]) & has[2]);
        trim_bad = has[3] ^ has[4];
        sh_bad = has[5] & (|has[4:0]);
    end
    // ========
    // Assertions
    // ========
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_UD_ERR: assert property ($past(ud_bad) |-> config_error) else $error("Bad raise/lower set");
    AST_TRIM_ERR: assert property ($past(trim_bad) |-> config_error) else $error("Lone trim input");
    AST_SH_ERR: assert property ($past(sh_bad) |-> config_error) else $error("Sample/hold clash");
    AST_NO_ERR: assert property (!$past(ud_bad) && !$past(trim_bad) && !$past(sh_bad) |-> !config_error)
        else $error("Error on valid set");
    AST_UPPER_RB: assert property ($past(rd) && $past(addr) == OFS_UPPER |-> rdata == $past(upper_sh))
        else $error("Upper readback");
    AST_TRIM_RB: assert property ($past(rd) && $past(addr) == OFS_TRIM |-> rdata == $past(trim_sh))
        else $error("Trim readback");
    // Both cycles off, so either reading of the enable edge passes
    AST_NV_OFF: assert property (!$past(hold_sh) && !hold_sh |-> nv_ref_out == '0)
        else $error("Kept reference with memory off");
    AST_AGREE_RUN: assert property (!$past(run_cmd) && !$past(run_cmd, 2) |-> !freq_agree)
        else $error("Agree while stopped");
    AST_STEP: assert property ($changed(out_freq) |-> out_freq == $past(out_freq) + 12'h001 ||
        out_freq == $past(out_freq) - 12'h001) else $error("Output jumped");
    CV_ERR: cover property ($rose(config_error));
    CV_AGREE: cover property (run_cmd && freq_agree);
    CV_UPPER_RD: cover property (rd && addr == OFS_UPPER);
endmodule : frf_adjust_sva

bind frf_adjust frf_adjust_sva #(.STEP_P(STEP_P), .SH_P(SH_P)) frf_adjust_sva_inst (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .run_cmd(run_cmd),
    .nv_ref_out(nv_ref_out), .out_freq(out_freq), .freq_agree(freq_agree), .config_error(config_error)
);

// ===== frf_contacts.sv
// Model of the contact switches and the analog reference source
module frf_contacts (
    input wire logic clk,
    output logic [frf_pkg::NUM_TERM-1:0] term_in,
    output frf_pkg::frf_freq_type analog_ref
);
    timeunit 1ns;
    timeprecision 100ps;
    import frf_pkg::*;
    // Open contacts and zero reference, never unknown
    initial begin
        term_in = '0;
        analog_ref = '0;
    end
    // Levels move just after an edge, like a synchronous contact
    task automatic set_level(input logic [NUM_TERM-1:0] t, input frf_freq_type a);
        @(posedge clk);
        term_in <= t;
        analog_ref <= a;
    endtask : set_level
    // Closed for n cycles; a sample/hold press under the sample time holds nothing
    task automatic press(input logic [NUM_TERM-1:0] t, input int n);
        @(posedge clk);
        term_in <= t;
        repeat (n) @(posedge clk);
        term_in <= '0;
    endtask : press
endmodule : frf_contacts

// ===== frf_adjust_tb.sv
// Self-checking testbench of the frequency reference adjust block
module frf_adjust_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import frf_pkg::*;
    // ========
    // Signals, counters and notes
    // ========
    localparam int unsigned STEP = 4; // Short counts keep the run brief
    localparam int unsigned SHC = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic run_cmd = 1'b0;
    logic preset_active = 1'b0;
    frf_freq_type preset_ref = '0;
    frf_freq_type nv_ref_in = '0;
    logic [31:0] rdata;
    logic [NUM_TERM-1:0] term_in;
    frf_freq_type analog_ref;
    frf_freq_type nv_ref_out;
    frf_freq_type out_freq;
    logic freq_agree;
    logic config_error;
    int mismatches = 0;
    int compares = 0;
    logic [15:0] seed = 16'h002A;
    logic [63:0] notes [$];
    logic [63:0] note;
    logic rd_seen = 1'b0;
    logic [31:0] v;
    logic [31:0] e;
    logic [39:0] cfg [8] = '{40'h00_0000_0010, 40'h00_0000_1110, 40'h00_000A_1110, 40'h00_0000_1C00,
        40'h00_0000_1D1C, 40'h1E_0000_1D1C, 40'h1E_0000_0000, 40'h1E_0000_000A};
    logic [7:0] cfg_err = 8'hAD;
    logic [1:0] trim_t [6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h1};
    frf_freq_type trim_a [6] = '{12'h12C, 12'h12C, 12'h12C, 12'h12C, 12'h032, 12'h000};
    always #2.5 clk = ~clk;
    frf_adjust #(.STEP_P(STEP), .SH_P(SHC)) frf_adjust_inst (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .term_in(term_in), .analog_ref(analog_ref), .run_cmd(run_cmd), .preset_active(preset_active),
        .preset_ref(preset_ref), .nv_ref_in(nv_ref_in), .nv_ref_out(nv_ref_out), .out_freq(out_freq),
        .freq_agree(freq_agree), .config_error(config_error)
    );
    frf_contacts frf_contacts_inst (.clk(clk), .term_in(term_in), .analog_ref(analog_ref));
    // ========
    // Tasks
    // ========
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic stop_test();
        $display("Compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        notes.push_back({m, x});
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg
    // Terminals 0 to 4, one selector byte each
    task automatic sel(input logic [39:0] s);
        for (int i = 0; i < 5; i++) wr_reg(OFS_TERM0 + 8'(4 * i), {24'h0, s[8 * i +: 8]});
    endtask : sel
    // Bounded: a ramp that never settles ends the run
    task automatic wait_agree();
        int n = 0;
        repeat (3) @(posedge clk);
        while (freq_agree !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n == 5000) begin
            mismatches++;
            stop_test();
        end
    endtask : wait_agree
    // Read data stands one cycle, so each note is settled at the next edge
    always @(posedge clk) begin
        if (rd_seen && notes.size() > 0) begin
            note = notes.pop_front();
            check(rdata & note[63:32], note[31:0]);
        end
        rd_seen = rd;
    end
    // ========
    // Scenarios
    // ========
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(OFS_UPPER, 32'h0000_03E8);
        rd_reg(OFS_LOWER, 32'h0000_0000);
        rd_reg(OFS_MLOWER, 32'h0000_0000);
        rd_reg(OFS_TRIM, 32'h0000_000A);
        // Random upper limits; above 110.0 % they bounce
        e = 32'h0000_03E8;
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            v = {21'h0, seed[10:0]};
            wr_reg(OFS_UPPER, v);
            if (v <= 32'h0000_044C) e = v;
            rd_reg(OFS_UPPER, e);
        end
        wr_reg(OFS_LOWER, 32'h0000_044D);
        rd_reg(OFS_LOWER, 32'h0000_0000);
        wr_reg(OFS_MLOWER, 32'h0000_044C);
        rd_reg(OFS_MLOWER, 32'h0000_044C);
        wr_reg(OFS_MLOWER, 32'h0000_0000);
        wr_reg(OFS_TRIM, 32'h0000_0065);
        rd_reg(OFS_TRIM, 32'h0000_000A);
        for (int i = 0; i < 8; i++) begin
            sel(cfg[i]);
            repeat (3) @(posedge clk);
            check({31'h0, config_error}, {31'h0, cfg_err[i]});
        end
        // Raise/lower held between analog floor and upper limit, presets ignored
        sel(40'h00_0000_1110);
        wr_reg(OFS_UPPER, 32'h0000_0014);
        frf_contacts_inst.set_level('0, 12'h00C);
        seed = lfsr(seed);
        preset_active <= 1'b1;
        preset_ref <= seed[11:0];
        run_cmd <= 1'b1;
        wait_agree();
        rd_reg(OFS_OUT_FREQ, 32'h0000_000C);
        check({20'h0, out_freq}, 32'h0000_000C);
        wr_reg(OFS_UPPER, 32'h0000_0007);
        rd_reg(OFS_UPPER, 32'h0000_0014);
        frf_contacts_inst.press(10'h001, 200);
        wait_agree();
        rd_reg(OFS_OUT_FREQ, 32'h0000_0014);
        check({31'h0, freq_agree}, 32'h0000_0001);
        frf_contacts_inst.press(10'h002, 200);
        wait_agree();
        rd_reg(OFS_OUT_FREQ, 32'h0000_000C);
        run_cmd <= 1'b0;
        preset_active <= 1'b0;
        // Kept reference over a power cycle, then cleared by a press
        nv_ref_in <= 12'h00F;
        repeat (2) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        sel(40'h00_0000_1110);
        wr_reg(OFS_UPPER, 32'h0000_0014);
        wr_reg(OFS_CTRL, 32'h0000_0003);
        frf_contacts_inst.set_level('0, 12'h000);
        run_cmd <= 1'b1;
        wait_agree();
        rd_reg(OFS_OUT_FREQ, 32'h0000_000F);
        check({20'h0, nv_ref_out}, 32'h0000_000F);
        frf_contacts_inst.press(10'h001, 1);
        rd_reg(OFS_UD_REF, 32'h0000_0000);
        // Two steps up, so the kept value is nonzero when memory goes off
        frf_contacts_inst.press(10'h001, 8);
        run_cmd <= 1'b0;
        wr_reg(OFS_CTRL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check({20'h0, nv_ref_out}, 32'h0000_0000);
        // Trim of 10 % is 100 in 0.1 % units
        sel(40'h00_1D1C_0000);
        wr_reg(OFS_UPPER, 32'h0000_03E8);
        run_cmd <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            e = {20'h0, trim_a[i]};
            if (e != 0 && trim_t[i] == 2'h1) e = e + 32'h0000_0064;
            if (trim_t[i] == 2'h2) e = (e > 32'h0000_0064) ? e - 32'h0000_0064 : 32'h0000_0000;
            frf_contacts_inst.set_level({6'h0, trim_t[i], 2'h0}, trim_a[i]);
            wait_agree();
            rd_reg(OFS_OUT_FREQ, e);
        end
        // Short press holds nothing, long press freezes the reference
        sel(40'h1E_0000_0000);
        frf_contacts_inst.set_level('0, 12'h0DE);
        frf_contacts_inst.press(10'h010, 10);
        rd_reg(OFS_STATUS, 32'h0000_0000, 32'h0000_0004);
        frf_contacts_inst.set_level('0, 12'h1BC);
        frf_contacts_inst.press(10'h010, 30);
        frf_contacts_inst.set_level('0, 12'h22B);
        wait_agree();
        rd_reg(OFS_OUT_FREQ, 32'h0000_01BC);
        rd_reg(OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
        // Let the pending read data be taken before reset wipes it
        repeat (2) @(posedge clk);
        run_cmd <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(OFS_STATUS, 32'h0000_0000, 32'h0000_0004);
        repeat (2) @(posedge clk);
        stop_test();
    end
endmodule : frf_adjust_tb
